//--- bench/spi_far_host.sv
/*
  behavioural far-side serial host: drives select, clock and data out, samples client data.
  assumes its tasks are called one at a time by the bench.
*/
`timescale 1ns/1ps
module spi_far_host (
  output logic      sck_o,
  output logic      mosi_o,
  output logic      ss_n_o,
  input  wire logic miso_i
);
  localparam realtime HALF = 62.5;
  initial begin
    sck_o  = 1'b0;
    mosi_o = 1'b0;
    ss_n_o = 1'b1;
  end
  task automatic sel(input logic lvl);
    ss_n_o = lvl;
    mosi_o = ~mosi_o;
  endtask
  task automatic xfer(input logic [1:0] mode, input int nbits, input logic [7:0] tx,
                      output logic [7:0] rx);
    int i;
    rx    = 8'h00;
    sck_o = mode[1];
    #200 ss_n_o = 1'b0;
    #200;
    for (i = 0; i < nbits; i++) begin
      if (!mode[0]) mosi_o = tx[7-i];
      #HALF sck_o = ~mode[1];
      if (mode[0]) mosi_o = tx[7-i];
      else rx = {rx[6:0], miso_i};
      #HALF sck_o = mode[1];
      if (mode[0]) rx = {rx[6:0], miso_i};
    end
    // released line toggles so a stale bit never looks like data
    #200 ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
  endtask
endmodule

//--- bench/spi_sel_client_tb.sv
/*
  self-checking bench for the serial select and client block.
  assumes the far-side host model and a 100 MHz core clock.
*/
`timescale 1ns/1ps
`include "spi_sel_consts.svh"
module spi_sel_client_tb;
  logic        clk_i;
  logic        nrst_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic        ss_dir_out_i;
  logic        miso_dir_out_i;
  logic [31:0] rdata_o;
  logic        miso_o, miso_oe_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, irq_o;
  logic        h_sck, h_mosi, h_ss_n;
  // data-out line assumed pulled up when nobody drives it
  wire         miso_w = miso_oe_o ? miso_o : 1'b1;
  wire         sck_w  = sck_oe_o ? sck_o : h_sck;
  wire         mosi_w = mosi_oe_o ? mosi_o : h_mosi;
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          m;
  logic [31:0] seed = 32'h0000F57E;
  logic [7:0]  tx, mo, rx, a, b;
  always #5 clk_i = ~clk_i;
  spi_sel_client dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ss_dir_out_i(ss_dir_out_i),
    .miso_dir_out_i(miso_dir_out_i), .ss_n_i(h_ss_n), .sck_i(sck_w), .mosi_i(mosi_w),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .irq_o(irq_o));
  spi_far_host host_u (.sck_o(h_sck), .mosi_o(h_mosi), .ss_n_o(h_ss_n), .miso_i(miso_w));
  function logic [7:0] rnd8();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [7:0] drop_host(input logic [7:0] v);
    return v & ~(8'h01 << `CA_HOST);
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= ad;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ad, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= ad;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask
  task automatic rchk(input logic [2:0] ad, input logic [7:0] e, input string n);
    logic [31:0] d;
    rd(ad, d);
    chk_reg(n, {24'h0, e}, d);
  endtask
  task automatic rbit(input int bi, input logic e, input string n);
    logic [31:0] d;
    rd(`OFS_FLAGS, d);
    chk_bit(n, e, d[bi]);
  endtask
  task automatic w8();
    repeat (8) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    clk_i          = 1'b0;
    nrst_i         = 1'b0;
    addr_i         = 3'h0;
    wdata_i        = 8'h00;
    wr_i           = 1'b0;
    rd_i           = 1'b0;
    ss_dir_out_i   = 1'b0;
    miso_dir_out_i = 1'b1;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    rchk(`OFS_CTRL_A, `CTRL_A_RST, "ctrl_a reset");
    rchk(`OFS_CTRL_B, `CTRL_B_RST, "ctrl_b reset");
    rchk(3'h7, 8'h00, "unmapped");
    wr(`OFS_INTCTRL, 8'h01);
    wr(`OFS_CTRL_A, 8'h21);
    host_u.sel(1'b0);
    w8();
    rchk(`OFS_CTRL_A, drop_host(8'h21), "host dropped");
    rbit(`FL_IF, 1'b1, "if on drop");
    chk_bit("irq", 1'b1, irq_o);
    wr(`OFS_FLAGS, 8'hFF);
    w8();
    chk_bit("irq cleared", 1'b0, irq_o);
    host_u.sel(1'b1);
    w8();
    rchk(`OFS_CTRL_A, 8'h01, "still client");
    wr(`OFS_CTRL_A, 8'h21);
    wr(`OFS_CTRL_B, 8'h01 << `CB_SEL_DIS);
    host_u.sel(1'b0);
    w8();
    rchk(`OFS_CTRL_A, 8'h21, "select ignored");
    chk_bit("sck oe host", 1'b1, sck_oe_o);
    chk_bit("mosi oe host", 1'b1, mosi_oe_o);
    chk_bit("sck idle host", 1'b0, sck_o);
    host_u.sel(1'b1);
    wr(`OFS_CTRL_B, 8'h00);
    ss_dir_out_i <= 1'b1;
    host_u.sel(1'b0);
    w8();
    rchk(`OFS_CTRL_A, 8'h21, "select as output");
    host_u.sel(1'b1);
    wr(`OFS_CTRL_A, 8'h01);
    ss_dir_out_i <= 1'b0;
    wr(`OFS_FLAGS, 8'hFF);
    w8();
    chk_bit("miso oe idle", 1'b0, miso_oe_o);
    host_u.sel(1'b0);
    w8();
    chk_bit("miso oe selected", 1'b1, miso_oe_o);
    chk_bit("sck oe client", 1'b0, sck_oe_o);
    chk_bit("mosi oe client", 1'b0, mosi_oe_o);
    miso_dir_out_i <= 1'b0;
    w8();
    chk_bit("miso oe as input", 1'b0, miso_oe_o);
    miso_dir_out_i <= 1'b1;
    host_u.sel(1'b1);
    w8();
    for (m = 0; m < 4; m++) begin
      wr(`OFS_CTRL_B, 8'(m));
      tx = rnd8();
      mo = rnd8();
      wr(`OFS_DATA, tx);
      rbit(`FL_IF, 1'b0, "idle while deselected");
      host_u.xfer(2'(m), 8, mo, rx);
      w8();
      chk_reg("miso byte", {24'h0, tx}, {24'h0, rx});
      rbit(`FL_IF, 1'b1, "byte done");
      rchk(`OFS_DATA, mo, "rx data");
    end
    wr(`OFS_CTRL_B, 8'h00);
    tx = rnd8();
    mo = rnd8();
    wr(`OFS_DATA, tx);
    fork
      host_u.xfer(2'h0, 8, mo, rx);
      begin
        #600;
        wr(`OFS_DATA, ~tx);
      end
    join
    w8();
    chk_reg("byte after collision", {24'h0, tx}, {24'h0, rx});
    rbit(`FL_WRITE_COLLISION_FLAG, 1'b1, "collision flag");
    wr(`OFS_FLAGS, 8'hFF);
    wr(`OFS_CTRL_B, 8'h01);
    wr(`OFS_DATA, rnd8());
    host_u.xfer(2'h1, 4, rnd8(), rx);
    w8();
    rbit(`FL_IF, 1'b0, "partial dropped");
    tx = rnd8();
    mo = rnd8();
    wr(`OFS_DATA, tx);
    rbit(`FL_WRITE_COLLISION_FLAG, 1'b0, "no collision after abort");
    host_u.xfer(2'h1, 8, mo, rx);
    w8();
    chk_reg("byte after abort", {24'h0, tx}, {24'h0, rx});
    rchk(`OFS_DATA, mo, "rx after abort");
    wr(`OFS_FLAGS, 8'hFF);
    wr(`OFS_CTRL_B, 8'h80);
    rbit(`FL_DRE, 1'b1, "buffer empty");
    a = rnd8();
    b = rnd8();
    wr(`OFS_DATA, a);
    rbit(`FL_DRE, 1'b0, "buffer written");
    host_u.xfer(2'h0, 8, rnd8(), rx);
    w8();
    chk_reg("dummy byte", {24'h0, mo}, {24'h0, rx});
    rbit(`FL_DRE, 1'b1, "buffer moved");
    rbit(`FL_RXC, 1'b1, "rx complete");
    rbit(`FL_TXC, 1'b0, "not all sent");
    wr(`OFS_DATA, b);
    wr(`OFS_DATA, ~b);
    host_u.xfer(2'h0, 8, rnd8(), rx);
    w8();
    chk_reg("first user byte", {24'h0, a}, {24'h0, rx});
    host_u.xfer(2'h0, 8, rnd8(), rx);
    w8();
    chk_reg("full write lost", {24'h0, b}, {24'h0, rx});
    rbit(`FL_TXC, 1'b1, "all sent");
    wr(`OFS_FLAGS, 8'hFF);
    wr(`OFS_CTRL_B, 8'hC0);
    tx = rnd8();
    wr(`OFS_DATA, tx);
    host_u.xfer(2'h0, 8, rnd8(), rx);
    w8();
    chk_reg("direct to shifter", {24'h0, tx}, {24'h0, rx});
    summarize();
  end
endmodule

//--- core/spi_sel_client.sv
/*
  serial peripheral block: host select arbitration, client shift engine in
  normal and buffered modes, four clock modes, byte register port.
  assumes sclk, mosi and select pins come from outside the clock domain; host
  clock generation is a simple divider since prescaler detail is out of scope.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "spi_sel_consts.svh"
module spi_sel_client (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic       ss_dir_out_i,
  input  wire logic       miso_dir_out_i,
  input  wire logic       ss_n_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  output logic            miso_o,
  output logic            miso_oe_o,
  output logic            sck_o,
  output logic            sck_oe_o,
  output logic            mosi_o,
  output logic            mosi_oe_o,
  output logic            irq_o
);
  logic [7:0] ctrl_a_r;
  logic [7:0] ctrl_b_r;
  logic [7:0] intctrl_r;
  logic [2:0] ss_s_r;
  logic [2:0] sck_s_r;
  logic [2:0] mosi_s_r;
  logic [2:0] miso_s_r;
  logic       ss_q_r;
  logic       sck_q_r;
  logic [7:0] shift_r;
  logic [7:0] txbuf_r;
  logic       txbuf_full_r;
  logic [7:0] rx_r;
  logic [7:0] rxbuf_r;
  logic [1:0] rx_cnt_r;
  logic [2:0] bit_cnt_r;
  logic       in_bit_r;
  logic       if_r;
  logic       write_collision_flag_r;
  logic       dre_r;
  logic       rxc_r;
  logic       txc_r;
  logic       ssi_r;
  logic       ovf_r;
  logic       dre_rise_r;
  logic       rxc_set_r;
  logic       dummy_pend_r;
  logic       load_pend_r;
  logic [7:0] div_r;
  logic       hsck_r;
  logic       host_busy_r;
  spi_sel_pkg::shift_state_t st_r;

  wire enable   = ctrl_a_r[`CA_ENABLE];
  wire host     = ctrl_a_r[`CA_HOST];
  wire lsb_first = ctrl_a_r[`CA_LSB_FIRST];
  wire buf_en   = ctrl_b_r[`CB_BUF_EN];
  wire buf_wr   = ctrl_b_r[`CB_BUF_WR];
  wire sel_dis  = ctrl_b_r[`CB_SEL_DIS];
  wire [1:0] mode = ctrl_b_r[`CB_MODE_LO +: 2];
  wire cpol     = mode[1];
  wire cpha     = mode[0];
  wire wr_data  = wr_i && addr_i == `OFS_DATA;
  wire wr_flags = wr_i && addr_i == `OFS_FLAGS;
  wire rd_data  = rd_i && addr_i == `OFS_DATA;

  // synchronised pins; select and clock filtered: change counts when stages two and three agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ss_s_r   <= 3'h7;
      sck_s_r  <= 3'h0;
      mosi_s_r <= 3'h0;
      miso_s_r <= 3'h0;
      ss_q_r   <= 1'b1;
      sck_q_r  <= 1'b0;
    end else begin
      ss_s_r   <= {ss_s_r[1:0], ss_n_i};
      sck_s_r  <= {sck_s_r[1:0], sck_i};
      mosi_s_r <= {mosi_s_r[1:0], mosi_i};
      miso_s_r <= {miso_s_r[1:0], miso_i};
      if (ss_s_r[1] == ss_s_r[2])
        ss_q_r <= ss_s_r[2];
      if (sck_s_r[1] == sck_s_r[2])
        sck_q_r <= sck_s_r[2];
    end
  end

  wire sck_now   = (sck_s_r[1] == sck_s_r[2]) ? sck_s_r[2] : sck_q_r;
  // client edge detect on sampled clock
  wire sck_edge  = sck_now != sck_q_r;
  // leading edge leaves idle level, trailing edge returns to it
  wire lead_edge = sck_edge && sck_q_r == cpol;
  wire trail_edge = sck_edge && sck_q_r != cpol;
  // capture on one edge, launch on the other
  wire cap_edge  = cpha ? trail_edge : lead_edge;
  wire lch_edge  = cpha ? lead_edge : trail_edge;
  // client always uses select, data in and clock as inputs
  wire client    = enable && !host;
  wire selected  = client && !ss_q_r;
  wire in_bit_c  = mosi_s_r[2];

  // arbitration only when select is an input and not disabled
  wire lose_host = enable && host && !sel_dis && !ss_dir_out_i && !ss_q_r;

  // host divider: ratio set by prescaler, halved by clk2x
  wire [7:0] half = ctrl_a_r[`CA_PRESC_LO +: 2] == 2'h0 ? 8'h01 :
                    ctrl_a_r[`CA_PRESC_LO +: 2] == 2'h1 ? 8'h07 :
                    ctrl_a_r[`CA_PRESC_LO +: 2] == 2'h2 ? 8'h1F : 8'h3F;
  wire [7:0] half_eff = ctrl_a_r[`CA_CLK2X] ? {1'b0, half[7:1]} : half;
  wire host_tick = host_busy_r && div_r == 8'h00;
  wire host_cap  = host_tick && (hsck_r == cpol) != cpha;
  wire host_lch  = host_tick && (hsck_r == cpol) == cpha;

  wire do_cap = host_busy_r ? host_cap : (selected && cap_edge);
  wire do_lch = host_busy_r ? host_lch : (selected && lch_edge);
  wire cap_bit = host_busy_r ? miso_s_r[2] : in_bit_c;
  wire byte_done = st_r == spi_sel_pkg::ST_SHIFT && bit_cnt_r == 3'h7 && do_cap;
  wire [7:0] rx_byte = lsb_first ? {cap_bit, shift_r[7:1]} : {shift_r[6:0], cap_bit};
  wire busy = st_r == spi_sel_pkg::ST_SHIFT || host_busy_r;

  // normal mode collision; full buffer drop
  wire norm_wr_ok = wr_data && !buf_en && !busy;
  wire buf_wr_ok  = wr_data && buf_en && !txbuf_full_r;
  // wait variant: deselected write goes straight on next cycle
  wire direct_ok  = buf_wr_ok && buf_wr && client && ss_q_r && !load_pend_r &&
                    dummy_pend_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_a_r  <= `CTRL_A_RST;
      ctrl_b_r  <= `CTRL_B_RST;
      intctrl_r <= 8'h00;
    end else begin
      if (wr_i && addr_i == `OFS_CTRL_A)
        ctrl_a_r <= wdata_i & 8'h77;
      // host bit cleared, stays so until rewritten
      else if (lose_host)
        ctrl_a_r[`CA_HOST] <= 1'b0;
      if (wr_i && addr_i == `OFS_CTRL_B)
        ctrl_b_r <= wdata_i & 8'hC7;
      if (wr_i && addr_i == `OFS_INTCTRL)
        intctrl_r <= wdata_i & 8'hF1;
    end
  end

  // serial state machine and data path
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r         <= spi_sel_pkg::ST_IDLE;
      bit_cnt_r    <= 3'h0;
      shift_r      <= 8'h00;
      txbuf_r      <= 8'h00;
      txbuf_full_r <= 1'b0;
      load_pend_r  <= 1'b0;
      dummy_pend_r <= 1'b1;
      host_busy_r  <= 1'b0;
      hsck_r       <= 1'b0;
      div_r        <= 8'h00;
      in_bit_r     <= 1'b0;
    end else begin
      if (!host_busy_r)
        hsck_r <= cpol;
      if (client && ss_q_r) begin
        st_r      <= spi_sel_pkg::ST_IDLE;
        bit_cnt_r <= 3'h0;
      end else if (selected && st_r == spi_sel_pkg::ST_IDLE && sck_edge) begin
        st_r <= spi_sel_pkg::ST_SHIFT;
      end
      if (do_cap) begin
        in_bit_r <= cap_bit;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        shift_r <= rx_byte;
        if (byte_done)
          st_r <= spi_sel_pkg::ST_IDLE;
      end
      if (host_tick) begin
        div_r  <= half_eff;
        hsck_r <= ~hsck_r;
        if (byte_done && ((hsck_r == cpol) != cpha))
          host_busy_r <= 1'b0;
      end else if (host_busy_r) begin
        div_r <= div_r - 8'h01;
      end
      // host transfer start from data write
      if (host && enable && wr_data && !busy && !buf_en) begin
        host_busy_r <= 1'b1;
        st_r        <= spi_sel_pkg::ST_SHIFT;
        div_r       <= half_eff;
      end
      if (norm_wr_ok)
        shift_r <= wdata_i;
      if (buf_wr_ok && !direct_ok) begin
        txbuf_r      <= wdata_i;
        txbuf_full_r <= 1'b1;
      end
      load_pend_r <= direct_ok;
      if (direct_ok)
        txbuf_r <= wdata_i;
      if (load_pend_r)
        shift_r <= txbuf_r;
      // after dummy transfer the buffer moves into the shifter
      // shifter is free again once a transfer ends with nothing to move in
      if (byte_done && buf_en) begin
        dummy_pend_r <= !txbuf_full_r;
        if (txbuf_full_r) begin
          shift_r      <= txbuf_r;
          txbuf_full_r <= 1'b0;
        end
      end
      if (direct_ok)
        dummy_pend_r <= 1'b0;
      if (!buf_en)
        dummy_pend_r <= 1'b1;
    end
  end

  // receive path: two-entry queue in buffer mode
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_r     <= 8'h00;
      rxbuf_r  <= 8'h00;
      rx_cnt_r <= 2'h0;
    end else begin
      if (byte_done && !buf_en) begin
        rx_r <= rx_byte;
      end else if (byte_done) begin
        if (rx_cnt_r == 2'h0)
          rx_r <= rx_byte;
        else
          rxbuf_r <= rx_byte;
        if (rx_cnt_r != 2'h2)
          rx_cnt_r <= rd_data ? rx_cnt_r : rx_cnt_r + 2'h1;
      end else if (rd_data && buf_en && rx_cnt_r != 2'h0) begin
        rx_r     <= rxbuf_r;
        rx_cnt_r <= rx_cnt_r - 2'h1;
      end
    end
  end

  // flags: hardware set wins over software clear by writing one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      if_r       <= 1'b0;
      write_collision_flag_r    <= 1'b0;
      dre_r      <= 1'b1;
      rxc_r      <= 1'b0;
      txc_r      <= 1'b0;
      ssi_r      <= 1'b0;
      ovf_r      <= 1'b0;
      dre_rise_r <= 1'b0;
      rxc_set_r  <= 1'b0;
    end else begin
      // transfer flag on forced drop or finished byte in normal mode
      if (lose_host || (byte_done && !buf_en))
        if_r <= 1'b1;
      else if ((wr_flags && wdata_i[`FL_IF]) || rd_data)
        if_r <= 1'b0;
      if (wr_data && !buf_en && busy)
        write_collision_flag_r <= 1'b1;
      else if (wr_flags && wdata_i[`FL_WRITE_COLLISION_FLAG])
        write_collision_flag_r <= 1'b0;
      // empty drops on a buffered write that is not a direct load, rises when buffer drains to shifter
      dre_rise_r <= byte_done && buf_en && txbuf_full_r;
      if (buf_wr_ok && !direct_ok)
        dre_r <= 1'b0;
      else if (byte_done && buf_en && txbuf_full_r)
        dre_r <= 1'b1;
      // receive complete one cycle after empty rises
      // a byte moved into the shifter is still unsent, so only a drained finish counts
      rxc_set_r <= byte_done && buf_en && !txbuf_full_r;
      if (dre_rise_r || (byte_done && buf_en && !txbuf_full_r))
        rxc_r <= 1'b1;
      else if (rd_data && rx_cnt_r == 2'h1)
        rxc_r <= 1'b0;
      // transfer complete when shifter and buffer both sent
      if (rxc_set_r && !txbuf_full_r)
        txc_r <= 1'b1;
      else if (wr_flags && wdata_i[`FL_TXC])
        txc_r <= 1'b0;
      if (buf_en && client && ss_q_r == 1'b0 && ss_s_r[2] && ss_s_r[1])
        ssi_r <= 1'b1;
      else if (wr_flags && wdata_i[`FL_SSI])
        ssi_r <= 1'b0;
      if (byte_done && buf_en && rx_cnt_r == 2'h2 && !rd_data)
        ovf_r <= 1'b1;
      else if (wr_flags && wdata_i[`FL_BUFOVF])
        ovf_r <= 1'b0;
    end
  end

  wire [7:0] flags_v = buf_en ? {rxc_r, txc_r, dre_r, ssi_r, 3'h0, ovf_r}
                              : {if_r, write_collision_flag_r, 6'h00};

  // read port and pins, all registered
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o   <= 32'h0000_0000;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
      sck_o     <= 1'b0;
      sck_oe_o  <= 1'b0;
      mosi_o    <= 1'b0;
      mosi_oe_o <= 1'b0;
      irq_o     <= 1'b0;
    end else begin
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        unique case (addr_i)
          `OFS_CTRL_A:  rdata_o[7:0] <= ctrl_a_r;
          `OFS_CTRL_B:  rdata_o[7:0] <= ctrl_b_r;
          `OFS_INTCTRL: rdata_o[7:0] <= intctrl_r;
          `OFS_FLAGS:   rdata_o[7:0] <= flags_v;
          `OFS_DATA:    rdata_o[7:0] <= rx_r;
          default:      rdata_o      <= 32'h0000_0000;
        endcase
      end
      miso_oe_o <= selected && miso_dir_out_i;
      miso_o    <= lsb_first ? shift_r[0] : shift_r[7];
      sck_oe_o  <= enable && host;
      sck_o     <= host_busy_r ? hsck_r : cpol;
      mosi_oe_o <= enable && host;
      mosi_o    <= lsb_first ? shift_r[0] : shift_r[7];
      irq_o     <= |(flags_v & (buf_en ? intctrl_r : {intctrl_r[0], 7'h00}));
    end
  end

  // forced drop takes effect next cycle
  a_host_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lose_host && !(wr_i && addr_i == `OFS_CTRL_A) |=> !ctrl_a_r[`CA_HOST])
    else $error("host bit not cleared by low select");
  a_drop_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
    lose_host |=> if_r)
    else $error("flag not set on forced drop");
  a_ssd_ignore: assert property (@(posedge clk_i) disable iff (!nrst_i)
    enable && host && (sel_dis || ss_dir_out_i) && !(wr_i && addr_i == `OFS_CTRL_A)
      |=> ctrl_a_r[`CA_HOST])
    else $error("select acted while disabled");
  a_idle_desel: assert property (@(posedge clk_i) disable iff (!nrst_i)
    client && ss_q_r |=> st_r == spi_sel_pkg::ST_IDLE)
    else $error("shifter ran while deselected");
  a_wr_collide: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_data && !buf_en && busy && !do_cap |=> write_collision_flag_r && $stable(shift_r))
    else $error("collision not flagged");
  a_full_drop: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_data && buf_en && txbuf_full_r && !byte_done |=> txbuf_r == $past(txbuf_r))
    else $error("full buffer overwritten");
  sequence s_dre_rise;
    !dre_r ##1 dre_r;
  endsequence
  a_rxc_after: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_dre_rise |=> rxc_r)
    else $error("receive complete late");
  a_miso_tri: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ss_q_r |=> !miso_oe_o)
    else $error("output driven while deselected");
endmodule

//--- core/spi_sel_consts.svh
/*
  offsets, field positions, reset values and timing counts for the serial block.
  assumes a plain register port with byte-wide data in the low bits of a 32-bit word.
*/
`ifndef SPI_SEL_CONSTS_SVH
`define SPI_SEL_CONSTS_SVH
`define OFS_CTRL_A      3'h0
`define OFS_CTRL_B      3'h1
`define OFS_INTCTRL     3'h2
`define OFS_FLAGS       3'h3
`define OFS_DATA        3'h4
`define CA_LSB_FIRST    6
`define CA_HOST         5
`define CA_CLK2X        4
`define CA_PRESC_LO     1
`define CA_ENABLE       0
`define CB_BUF_EN       7
`define CB_BUF_WR       6
`define CB_SEL_DIS      2
`define CB_MODE_LO      0
`define FL_IF           7
`define FL_WRITE_COLLISION_FLAG        6
`define FL_RXC          7
`define FL_TXC          6
`define FL_DRE          5
`define FL_SSI          4
`define FL_BUFOVF       0
`define CTRL_A_RST      8'h00
`define CTRL_B_RST      8'h00
`define SAMPLE_MIN_NS   20
`define CLK_NS          10
`define SAMPLE_MIN_CYC  ((`SAMPLE_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- core/spi_sel_pkg.sv
/*
  types for the serial select and client block.
  assumes the constants header is included by the design file.
*/
package spi_sel_pkg;
  typedef enum logic [1:0] {
    MODE0,
    MODE1,
    MODE2,
    MODE3
  } spi_mode_t;
  typedef enum logic {
    ST_IDLE,
    ST_SHIFT
  } shift_state_t;
endpackage
